// ===== verilog/speed_nvm_pkg.sv
// Package: register map, field layout, reset values and timing for the speed and NVM register bank
package speed_nvm_pkg;

    // Register word width and register address width
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;

    // Register addresses
    localparam logic [7:0] ADDR_DEVICE_IDENTITY     = 8'h08;
    localparam logic [7:0] ADDR_UNUSED_FIRST        = 8'h09;
    localparam logic [7:0] ADDR_UNUSED_LAST         = 8'h2F;
    localparam logic [7:0] ADDR_HOST_SPEED_COMMAND  = 8'h30;
    localparam logic [7:0] ADDR_NVM_UNLOCK_KEY      = 8'h31;
    localparam logic [7:0] ADDR_NVM_READY_STATUS    = 8'h32;
    localparam logic [7:0] ADDR_NVM_SINGLE_ADDRESS  = 8'h33;
    localparam logic [7:0] ADDR_NVM_SINGLE_WDATA    = 8'h34;
    localparam logic [7:0] ADDR_NVM_ACCESS_CTRL     = 8'h35;
    localparam logic [7:0] ADDR_NVM_SINGLE_RDATA    = 8'h36;

    // Field positions
    localparam int unsigned SPEED_SELECT_BIT = 15;
    localparam int unsigned SPEED_VALUE_W    = 9;
    localparam int unsigned ACC_TYPE_LSB     = 0;
    localparam int unsigned WRITE_SEL_BIT    = 2;
    localparam int unsigned READY_BIT        = 0;

    // Key that opens the customer configuration space
    localparam logic [15:0] NVM_UNLOCK_VALUE = 16'hC0DE;
    // Customer configuration window in the non-volatile array
    localparam logic [7:0]  CFG_FIRST        = 8'h90;
    localparam logic [7:0]  CFG_LAST         = 8'h96;

    // Reset values
    localparam logic [15:0] RESET_WORD       = 16'h0000;

    // Counting cycles of an array access; the ready flag stays low one cycle longer
    localparam int unsigned NVM_BUSY_CYCLES  = 4;

    // Access type encodings
    typedef enum logic [1:0] {
        ACC_OFF    = 2'b00,
        ACC_SINGLE = 2'b01,
        ACC_MASS   = 2'b10,
        ACC_RSVD   = 2'b11
    } nvm_access_type_t;

    // Register port request
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Access sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_BUSY  = 2'b01,
        SEQ_DONE  = 2'b10
    } seq_state_t;

endpackage : speed_nvm_pkg

// ===== verilog/nvm_word_array.sv
// Small word memory standing in for the customer configuration array
`timescale 1ns/100ps
`default_nettype none
module nvm_word_array
    import speed_nvm_pkg::*;
#(
    parameter int unsigned DEPTH = 7,
    parameter int unsigned WIDTH = 16
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] index,
    input  wire logic [WIDTH-1:0]         wdata,
    output var  logic [WIDTH-1:0]         rdata_q
);
    // Refuse sizes the index cannot serve
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad_size
        $error("nvm_word_array: unsupported size");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];  // Stored words, no reset: models an array

    // Write port and registered read port
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem_q[index] <= wdata;
        end
        if (!resetn)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= mem_q[index];
        end
    end
endmodule : nvm_word_array
`default_nettype wire

// ===== verilog/speed_nvm_regs.sv
// Register bank: identity, host speed command and NVM individual access
// Summary of operation
// - Upper identity byte: read-only die identifier
// - Lower identity byte: read-only silicon revision
// - Addresses 0x09 to 0x2F have no function
// - Select bit hands speed command to host
// - Nine-bit speed value, bits 14:9 reserved
// - Speed-command register resets to zero
// - Key unlocks configuration locations 0x90-0x96
// - Bit 0 reports array ready
// - Low byte selects single-access location
// - Address 0x90 targets first configuration word
// - Access type: off, single, mass, reserved
// - Write select: 0 read, 1 write
// - Single write stores write-data word
// - Single read returns word in read-data
`timescale 1ns/100ps
`default_nettype none
module speed_nvm_regs
    import speed_nvm_pkg::*;
#(
    parameter logic [7:0] DIE_IDENTIFIER   = 8'h5A,  // Arbitrary value
    parameter logic [7:0] SILICON_REVISION = 8'h00,  // Arbitrary value
    parameter int unsigned CFG_WORDS       = 7
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire reg_req_t                 reg_req,          // Register access from I2C side
    input  wire logic [SPEED_VALUE_W-1:0] pin_speed,        // Speed from pin path
    input  wire logic                     nvm_single_start, // Launch a single access
    output logic [15:0]                   reg_rdata,        // Read data, registered
    output logic                          reg_rvalid,       // Read data valid pulse
    output logic [SPEED_VALUE_W-1:0]      motor_speed_cmd,  // Chosen speed command
    output logic                          nvm_ready_flag    // Array ready level
);
    // Refuse array sizes that do not cover the configuration window
    if (CFG_WORDS != int'(CFG_LAST - CFG_FIRST) + 1)
    begin : g_bad_cfg_words
        $error("speed_nvm_regs: CFG_WORDS must cover the window");
    end
    // The busy counter is three bits wide and must count at least one cycle
    if (NVM_BUSY_CYCLES < 1 || NVM_BUSY_CYCLES > 8)
    begin : g_bad_busy_cycles
        $error("speed_nvm_regs: NVM_BUSY_CYCLES out of range");
    end
    // The array index is three bits wide, which a larger window would overflow
    if (CFG_WORDS > 8)
    begin : g_bad_index
        $error("speed_nvm_regs: window too large for the array index");
    end

    // Whole module state in one packed struct
    // Host-visible fields come first, then the sequencer and the output copies.
    // Clearing the struct on reset gives every register its zero reset value.
    typedef struct packed {
        logic                     host_speed_select;
        logic [SPEED_VALUE_W-1:0] host_speed_value;
        logic [15:0]              nvm_unlock_key;
        logic [7:0]               nvm_single_addr;
        logic [15:0]              nvm_single_wdata;
        logic [1:0]               nvm_access_type;
        logic                     nvm_write_select;
        logic [15:0]              nvm_single_rdata;
        seq_state_t               seq;
        logic [2:0]               busy_cnt;
        logic                     rd_pend;
        logic [15:0]              rdata;
        logic                     rvalid;
        logic [SPEED_VALUE_W-1:0] speed_out;
        logic                     ready;
    } state_t;

    state_t s_q;  // Registered state
    state_t s_d;  // Next state

    // Decode of the host registers for the sequencer
    logic        unlocked;     // Key currently matches
    logic        addr_in_cfg;  // Address falls in configuration window
    logic        mem_wr;       // Array write strobe
    logic [2:0]  mem_index;    // Array word index
    logic [15:0] mem_rdata;    // Array read data, registered in the memory

    // The key is compared on every cycle, so writing any other value to the
    // key register locks the window again at once
    assign unlocked    = (s_q.nvm_unlock_key == NVM_UNLOCK_VALUE);
    assign addr_in_cfg = (s_q.nvm_single_addr >= CFG_FIRST)
                      && (s_q.nvm_single_addr <= CFG_LAST);
    // Offset from the first word, so 0x90 maps to index 0
    assign mem_index   = 3'(s_q.nvm_single_addr - CFG_FIRST);
    assign mem_wr      = (s_q.seq == SEQ_BUSY) && (s_q.busy_cnt == 3'd0)
                      && s_q.nvm_write_select;

    // Array word store. Its contents survive reset, as a non-volatile store
    // would; only its read register is cleared. The index and write data come
    // straight from the host registers, so the host must leave them alone
    // until ready returns, or the access lands on the new location.
    nvm_word_array #(
        .DEPTH (CFG_WORDS),
        .WIDTH (16)
    ) u_array (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .wr_en   (mem_wr),
        .index   (mem_index),
        .wdata   (s_q.nvm_single_wdata),
        .rdata_q (mem_rdata)
    );

    // Next-state logic: register writes, reads and the access sequencer
    always_comb
    begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        // Host writes; read-only and unmapped addresses drop the write
        if (reg_req.wr_en)
        begin
            case (reg_req.addr)
                ADDR_HOST_SPEED_COMMAND:
                begin
                    s_d.host_speed_select = reg_req.wdata[SPEED_SELECT_BIT];
                    s_d.host_speed_value  = reg_req.wdata[SPEED_VALUE_W-1:0];
                end
                // Any value is stored; only the exact key opens the window
                ADDR_NVM_UNLOCK_KEY:   s_d.nvm_unlock_key   = reg_req.wdata;
                ADDR_NVM_SINGLE_WDATA: s_d.nvm_single_wdata = reg_req.wdata;
                // Address field is writable here so software can aim accesses
                ADDR_NVM_SINGLE_ADDRESS: s_d.nvm_single_addr = reg_req.wdata[7:0];
                ADDR_NVM_ACCESS_CTRL:
                begin
                    s_d.nvm_access_type  = reg_req.wdata[ACC_TYPE_LSB +: 2];
                    s_d.nvm_write_select = reg_req.wdata[WRITE_SEL_BIT];
                end
                default: ;  // Identity, holes and status ignore writes
            endcase
        end
        // Host reads; every hole and reserved bit returns zero
        // A read returns the value held before any write in the same cycle
        if (reg_req.rd_en)
        begin
            s_d.rvalid = 1'b1;
            case (reg_req.addr)
                ADDR_DEVICE_IDENTITY:    s_d.rdata = {DIE_IDENTIFIER, SILICON_REVISION};
                ADDR_HOST_SPEED_COMMAND: s_d.rdata = {s_q.host_speed_select, 6'h00,
                                                      s_q.host_speed_value};
                ADDR_NVM_UNLOCK_KEY:     s_d.rdata = s_q.nvm_unlock_key;
                ADDR_NVM_READY_STATUS:   s_d.rdata = {15'h0000, s_q.ready};
                ADDR_NVM_SINGLE_ADDRESS: s_d.rdata = {8'h00, s_q.nvm_single_addr};
                ADDR_NVM_SINGLE_WDATA:   s_d.rdata = s_q.nvm_single_wdata;
                ADDR_NVM_ACCESS_CTRL:    s_d.rdata = {13'h0000, s_q.nvm_write_select,
                                                      s_q.nvm_access_type};
                ADDR_NVM_SINGLE_RDATA:   s_d.rdata = s_q.nvm_single_rdata;
                default:                 s_d.rdata = RESET_WORD;
            endcase
        end
        // A launch holds ready low for NVM_BUSY_CYCLES cycles of counting and
        // one more to collect the read word, then raises it again. Mass access
        // is accepted in the type field but never launches anything; a start
        // in that mode, or in the reserved mode, is dropped without a trace.
        // Access sequencer: only single mode, unlocked, inside the window
        case (s_q.seq)
            SEQ_IDLE:
            begin
                s_d.ready = 1'b1;
                if (nvm_single_start && s_q.ready
                    && (s_q.nvm_access_type == ACC_SINGLE) && unlocked && addr_in_cfg)
                begin
                    s_d.seq      = SEQ_BUSY;
                    s_d.busy_cnt = 3'(NVM_BUSY_CYCLES - 1);
                    s_d.ready    = 1'b0;
                    s_d.rd_pend  = !s_q.nvm_write_select;
                end
            end
            SEQ_BUSY:
            begin
                // The write strobe fires on the last counting cycle
                if (s_q.busy_cnt == 3'd0)
                begin
                    s_d.seq = SEQ_DONE;
                end
                else
                begin
                    s_d.busy_cnt = s_q.busy_cnt - 3'd1;
                end
            end
            SEQ_DONE:
            begin
                // Memory read data is registered, so it is valid one cycle after BUSY
                if (s_q.rd_pend)
                begin
                    s_d.nvm_single_rdata = mem_rdata;
                end
                s_d.rd_pend = 1'b0;
                s_d.ready   = 1'b1;
                s_d.seq     = SEQ_IDLE;
            end
            default: s_d.seq = SEQ_IDLE;
        endcase
        // Speed command source: host value only while select is set
        // The choice is registered, so a new source or a new pin value shows
        // on the output one cycle later; the pin path is not filtered here.
        s_d.speed_out = s_q.host_speed_select ? s_q.host_speed_value : pin_speed;
    end

    // State register; reset clears the whole struct
    // Reset is synchronous; the sequencer returns to idle with ready low, and
    // ready rises on the first edge after reset is released.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    // Each output is a state field, so no port carries combinational logic
    assign reg_rdata       = s_q.rdata;
    assign reg_rvalid      = s_q.rvalid;
    assign motor_speed_cmd = s_q.speed_out;
    assign nvm_ready_flag  = s_q.ready;
endmodule : speed_nvm_regs
`default_nettype wire

// ===== verification/speed_nvm_chk.sv
// Checker: port-level properties of the speed and NVM register bank
`timescale 1ns/100ps
`default_nettype none
module speed_nvm_chk
    import speed_nvm_pkg::*;
#(
    parameter logic [7:0]  DIE_IDENTIFIER   = 8'h00,
    parameter logic [7:0]  SILICON_REVISION = 8'h00,
    parameter int unsigned CFG_WORDS        = 7
)
(
    input wire logic                     clk_sys,
    input wire logic                     resetn,
    input wire reg_req_t                 reg_req,
    input wire logic [SPEED_VALUE_W-1:0] pin_speed,
    input wire logic                     nvm_single_start,
    input wire logic [15:0]              reg_rdata,
    input wire logic                     reg_rvalid,
    input wire logic [SPEED_VALUE_W-1:0] motor_speed_cmd,
    input wire logic                     nvm_ready_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [15:0] sh_q [8];                          // Shadow of writes to 0x30..0x37
    wire  rd  = reg_req.rd_en && !reg_req.wr_en;    // Plain read, no write alongside
    wire  sel = sh_q[0][15];                        // Host owns the speed command
    wire  [8:0] val = sh_q[0][8:0];                 // Host speed value
    wire  ok = sh_q[1] == NVM_UNLOCK_VALUE && sh_q[5][1:0] == ACC_SINGLE
               && sh_q[3][7:0] inside {[CFG_FIRST:CFG_LAST]}; // Start would be taken
    // Shadow is kept here so refusals can be predicted without peeking inside
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            sh_q <= '{default: '0};
        else if (reg_req.wr_en && reg_req.addr[7:3] == 5'b00110)
            sh_q[reg_req.addr[2:0]] <= reg_req.wdata;
    end
    sequence s_busy;
        !nvm_ready_flag [*5] ##1 nvm_ready_flag;
    endsequence
    property p_ident; rd && reg_req.addr == ADDR_DEVICE_IDENTITY
        |=> reg_rdata == {DIE_IDENTIFIER, SILICON_REVISION}; endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong");
    property p_hole; rd && reg_req.addr inside {[ADDR_UNUSED_FIRST:ADDR_UNUSED_LAST]}
        |=> reg_rdata == '0; endproperty
    a_hole: assert property (p_hole) else $error("unused address not zero");
    property p_spd; rd && reg_req.addr == ADDR_HOST_SPEED_COMMAND
        |=> reg_rdata == ($past(sh_q[0]) & 16'h81FF); endproperty
    a_spd: assert property (p_spd) else $error("speed register wrong");
    property p_pin; $past(resetn) && !sel && !$past(sel)
        |-> motor_speed_cmd == $past(pin_speed); endproperty
    a_pin: assert property (p_pin) else $error("pin speed not followed");
    property p_host; sel && $past(sel) && $past(val) == val
        |-> motor_speed_cmd == val; endproperty
    a_host: assert property (p_host) else $error("host speed not used");
    property p_busy; $fell(nvm_ready_flag) |-> s_busy; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_refuse; nvm_single_start && nvm_ready_flag && !ok
        |=> nvm_ready_flag [*3]; endproperty
    a_refuse: assert property (p_refuse) else $error("bad start taken");
    property p_accept; nvm_single_start && nvm_ready_flag && ok
        |-> ##[1:2] !nvm_ready_flag; endproperty
    a_accept: assert property (p_accept) else $error("good start ignored");
    property p_rvalid; reg_req.rd_en |=> reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid missing");
    property p_rquiet; !reg_req.rd_en |=> !reg_rvalid; endproperty
    a_rquiet: assert property (p_rquiet) else $error("read valid without read");
endmodule : speed_nvm_chk
bind speed_nvm_regs speed_nvm_chk #(
    .DIE_IDENTIFIER(DIE_IDENTIFIER),
    .SILICON_REVISION(SILICON_REVISION),
    .CFG_WORDS(CFG_WORDS)
) chk_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .pin_speed(pin_speed),
    .nvm_single_start(nvm_single_start), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .motor_speed_cmd(motor_speed_cmd), .nvm_ready_flag(nvm_ready_flag));
`default_nettype wire

// ===== verification/host_model.sv
// Host model: register requests and array access launches
`timescale 1ns/100ps
`default_nettype none
module host_model
    import speed_nvm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    input  wire logic        nvm_ready_flag,
    output var  reg_req_t    reg_req,
    output var  logic        nvm_single_start
);
    initial
    begin
        reg_req          = '0;
        nvm_single_start = 1'b0;
    end
    // Released fields go inverted, so a late sample shows garbage
    task automatic req(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1 reg_req = '{w, ~w, a, d};
        @(posedge clk_sys);
        #1 reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : req
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req(1'b1, a, d); // Key, select and data go by plain writes
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        req(1'b0, a, 16'h0000);
        d = reg_rvalid ? reg_rdata : 16'hxxxx; // Data only counts with valid
    endtask : rd
    // Launch once ready is seen; a stuck flag ends the wait and is reported
    task automatic start(output logic seen);
        seen = nvm_ready_flag;
        for (int i = 0; i < 16 && !seen; i++)
        begin
            @(posedge clk_sys);
            #1 seen = nvm_ready_flag;
        end
        @(posedge clk_sys);
        #1 nvm_single_start = 1'b1;
        @(posedge clk_sys);
        #1 nvm_single_start = 1'b0;
    endtask : start
endmodule : host_model
`default_nettype wire

// ===== verification/testbench.sv
// Testbench: register access sequences with expected values
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import speed_nvm_pkg::*;
    localparam logic [7:0] DIE_ID = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV_ID = 8'h02; // Arbitrary value
    logic         clk_sys   = 1'b0;
    logic         resetn    = 1'b0;
    logic [8:0]   pin_speed = 9'h1A5;
    reg_req_t     reg_req;
    logic         nvm_single_start;
    logic [15:0]  reg_rdata;
    logic         reg_rvalid;
    logic [8:0]   cmd;
    logic         rdy;
    int           fail_count = 0;
    int           n_checks   = 0;
    logic [15:0]  d;
    logic [7:0]   holes [3] = '{8'h09, 8'h2F, 8'h37};
    always #12.5 clk_sys = ~clk_sys;
    speed_nvm_regs #(.DIE_IDENTIFIER(DIE_ID), .SILICON_REVISION(REV_ID), .CFG_WORDS(7))
    speed_nvm_regs_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
        .pin_speed(pin_speed), .nvm_single_start(nvm_single_start), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .motor_speed_cmd(cmd), .nvm_ready_flag(rdy));
    host_model host_model_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .nvm_ready_flag(rdy), .reg_req(reg_req),
        .nvm_single_start(nvm_single_start));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
        host_model_inst.rd(a, d);
        chk(nm, e, d);
    endtask : rc
    task automatic end_sim();
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // Set up and launch one access, then watch the ready flag for a fixed window
    task automatic go(input logic [7:0] a, input logic [15:0] w, c, input logic busy);
        logic low;
        logic seen;
        low = 1'b0;
        host_model_inst.wr(ADDR_NVM_SINGLE_ADDRESS, {8'h00, a});
        host_model_inst.wr(ADDR_NVM_SINGLE_WDATA, w);
        host_model_inst.wr(ADDR_NVM_ACCESS_CTRL, c);
        host_model_inst.start(seen);
        if (!seen)
        begin
            fail_count++;
            $display("mismatch ready_wait expected 1 seen 0");
            end_sim();
        end
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_sys);
            #1 low = low | !rdy;
        end
        chk("busy", {15'h0, busy}, {15'h0, low});
        chk("ready", 16'h0001, {15'h0, rdy});
    endtask : go
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1 resetn = 1'b1;
        rc("speed", ADDR_HOST_SPEED_COMMAND, RESET_WORD);
        host_model_inst.wr(ADDR_DEVICE_IDENTITY, 16'hFFFF);
        rc("ident", ADDR_DEVICE_IDENTITY, {DIE_ID, REV_ID});
        foreach (holes[i])
        begin
            host_model_inst.wr(holes[i], 16'hFFFF);
            rc("hole", holes[i], 16'h0000);
        end
        host_model_inst.wr(ADDR_NVM_READY_STATUS, 16'hFFFE);
        rc("status", ADDR_NVM_READY_STATUS, 16'h0001);
        chk("pin", 16'h01A5, {7'h0, cmd});
        host_model_inst.wr(ADDR_HOST_SPEED_COMMAND, 16'hFFFF);
        rc("speed", ADDR_HOST_SPEED_COMMAND, 16'h81FF);
        chk("host", 16'h01FF, {7'h0, cmd});
        @(posedge clk_sys);
        #1 pin_speed = 9'h05A;
        repeat (2) @(posedge clk_sys);
        #1 chk("host", 16'h01FF, {7'h0, cmd});
        host_model_inst.wr(ADDR_HOST_SPEED_COMMAND, 16'h0123);
        rc("speed", ADDR_HOST_SPEED_COMMAND, 16'h0123);
        chk("pin", 16'h005A, {7'h0, cmd});
        host_model_inst.wr(ADDR_NVM_SINGLE_ADDRESS, 16'hFF90);
        rc("addr", ADDR_NVM_SINGLE_ADDRESS, 16'h0090);
        go(8'h90, 16'hBEEF, 16'h0005, 1'b0);
        host_model_inst.wr(ADDR_NVM_UNLOCK_KEY, NVM_UNLOCK_VALUE);
        rc("key", ADDR_NVM_UNLOCK_KEY, NVM_UNLOCK_VALUE);
        go(8'h90, 16'hBEEF, 16'h0004, 1'b0);
        go(8'h90, 16'hBEEF, 16'h0006, 1'b0);
        go(8'h97, 16'hBEEF, 16'h0005, 1'b0);
        go(8'h90, 16'h1234, 16'h0005, 1'b1);
        go(8'h96, 16'hABCD, 16'h0005, 1'b1);
        go(8'h90, 16'h0000, 16'h0001, 1'b1);
        rc("rdata", ADDR_NVM_SINGLE_RDATA, 16'h1234);
        go(8'h96, 16'h0000, 16'h0001, 1'b1);
        rc("rdata", ADDR_NVM_SINGLE_RDATA, 16'hABCD);
        host_model_inst.wr(ADDR_HOST_SPEED_COMMAND, 16'h8055);
        @(posedge clk_sys);
        #1 resetn = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        rc("speed", ADDR_HOST_SPEED_COMMAND, RESET_WORD);
        rc("key", ADDR_NVM_UNLOCK_KEY, 16'h0000);
        chk("pin", 16'h005A, {7'h0, cmd});
        end_sim();
    end
endmodule : testbench
`default_nettype wire
